// ===== design/tbt_ber_tester.sv
/*
  Per-stream bit error rate tester: register file on the synchronous
  microprocessor port, channel window per receiver, 32 stream lanes.
  Assumes the switch supplies a one-cycle bit strobe, the current channel
  number, per-stream pattern selects from connection memory and input bits.
*/
`timescale 1ns/1ps
`include "tbt_defs.svh"

module tbt_ber_tester (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      cs,
  input  wire logic                      rd,
  input  wire logic                      wr,
  input  wire logic [`TBT_ADDR_W-1:0]    addr,
  input  wire logic [`TBT_DATA_W-1:0]    wdata,
  output logic      [`TBT_DATA_W-1:0]    rdata,
  output logic                           rdy,
  input  wire logic                      bit_en,
  input  wire logic [7:0]                chan_num,
  input  wire logic [`TBT_STREAMS-1:0]   tx_sel,
  input  wire logic [`TBT_STREAMS-1:0]   rx_bit,
  output logic      [`TBT_STREAMS-1:0]   tx_bit,
  output logic                           soft_reset_clock_loop
);

  tbt_pkg::tbt_cfg_s          cfg [`TBT_STREAMS];
  logic [`TBT_DATA_W-1:0]     internal_mode_register;
  logic [1:0]                 soft_reset_register;
  logic [`TBT_DATA_W-1:0]     err [`TBT_STREAMS];
  logic [`TBT_STREAMS-1:0]    clr;
  logic [`TBT_STREAMS-1:0]    in_win;
  logic                       sw_rst;
  logic                       global_tx_test_enable;
  logic                       global_rx_test_enable;
  logic                       wr_go;
  logic                       rd_go;
  logic [4:0]                 idx;
  logic [`TBT_ADDR_W-1:0]     grp;
  tbt_pkg::tbt_word_t         next_rdata;
  logic [`TBT_STREAMS-1:0]    rx_on;
  logic [7:0]                 start_chan [`TBT_STREAMS];
  logic [8:0]                 len_chan [`TBT_STREAMS];
  logic [8:0]                 win_end [`TBT_STREAMS];
  logic [`TBT_STREAMS-1:0]    lane_tx_go;
  logic [`TBT_STREAMS-1:0]    lane_rx_en;
  logic [`TBT_STREAMS-1:0]    lane_rx_go;
  logic                       mode_hit;
  logic                       srst_hit;
  logic                       ctrl_hit;
  logic                       start_hit;
  logic                       len_hit;
  logic                       err_hit;

  assign wr_go = cs && wr;
  assign rd_go = cs && rd;
  assign idx   = addr[4:0];
  assign grp   = {addr[`TBT_ADDR_W-1:5], 5'h00};

  // Register decode, per-stream groups of 32
  assign mode_hit  = (addr == `TBT_OFS_MODE);
  assign srst_hit  = (addr == `TBT_OFS_SRST);
  assign ctrl_hit  = (grp == `TBT_OFS_CTRL);
  assign start_hit = (grp == `TBT_OFS_START);
  assign len_hit   = (grp == `TBT_OFS_LEN);
  assign err_hit   = (grp == `TBT_OFS_ERR);

  // switch soft reset held while its bit is set
  assign sw_rst = soft_reset_register[`TBT_SRST_SWITCH];
  assign global_tx_test_enable = internal_mode_register[`TBT_MODE_TX_EN];
  assign global_rx_test_enable = internal_mode_register[`TBT_MODE_RX_EN];

  // Soft reset register, cleared only by a write or the hardware reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_reset_register   <= 2'h0;
      soft_reset_clock_loop <= 1'b0;
    end else if (wr_go && srst_hit) begin
      soft_reset_register   <= wdata[1:0];
      soft_reset_clock_loop <= wdata[`TBT_SRST_LOOP];
    end
  end

  // mode register, both test enables off after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_mode_register <= `TBT_MODE_RESET;
    end else if (sw_rst) begin
      internal_mode_register <= `TBT_MODE_RESET;
    end else if (wr_go && mode_hit) begin
      internal_mode_register <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_on <= '0;
    end else if (sw_rst) begin
      rx_on <= '0;
    end else if (wr_go && ctrl_hit) begin
      rx_on[idx] <= wdata[`TBT_CTRL_EN];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `TBT_STREAMS; i++) begin
        start_chan[i] <= 8'h00;
      end
    end else if (sw_rst) begin
      for (int i = 0; i < `TBT_STREAMS; i++) begin
        start_chan[i] <= 8'h00;
      end
    end else if (wr_go && start_hit) begin
      start_chan[idx] <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `TBT_STREAMS; i++) begin
        len_chan[i] <= 9'h000;
      end
    end else if (sw_rst) begin
      for (int i = 0; i < `TBT_STREAMS; i++) begin
        len_chan[i] <= 9'h000;
      end
    end else if (wr_go && len_hit) begin
      len_chan[idx] <= wdata[8:0];
    end
  end

  // Configuration view for window and read-back
  always_comb begin
    for (int i = 0; i < `TBT_STREAMS; i++) begin
      cfg[i].en    = rx_on[i];
      cfg[i].start = start_chan[i];
      cfg[i].len   = len_chan[i];
    end
  end

  always_comb begin
    clr = '0;
    if (wr_go && ctrl_hit && wdata[`TBT_CTRL_CLR]) begin
      clr[idx] = 1'b1;
    end
  end

  // channel window start..start+len-1, length zero compares none
  always_comb begin
    for (int i = 0; i < `TBT_STREAMS; i++) begin
      // Nine-bit end, legal windows stay below 512
      win_end[i] = {1'b0, cfg[i].start} + cfg[i].len;
      in_win[i]  = ({1'b0, chan_num} >= {1'b0, cfg[i].start}) &&
                   ({1'b0, chan_num} < win_end[i]);
    end
  end

  // pattern steps on every selected channel bit while the transmit test enable is set
  always_comb begin
    for (int i = 0; i < `TBT_STREAMS; i++) begin
      lane_tx_go[i] = bit_en && tx_sel[i] && global_tx_test_enable;
      lane_rx_en[i] = rx_on[i] && global_rx_test_enable;
      lane_rx_go[i] = bit_en && in_win[i] && lane_rx_en[i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TBT_STREAMS; g++) begin : g_lane
      tbt_lane u_lane (
        .clk     (clk),
        .nrst    (nrst),
        .sw_rst  (sw_rst),
        .tx_go   (lane_tx_go[g]),
        .rx_en   (lane_rx_en[g]),
        .rx_go   (lane_rx_go[g]),
        .rx_bit  (rx_bit[g]),
        .clr     (clr[g]),
        .tx_bit  (tx_bit[g]),
        .err_cnt (err[g])
      );
    end
  endgenerate

  // Read decode, unmapped addresses return zero
  always_comb begin
    next_rdata = '0;
    if (mode_hit) begin
      next_rdata = internal_mode_register;
    end else if (srst_hit) begin
      next_rdata = {14'h0000, soft_reset_register};
    end else if (ctrl_hit) begin
      next_rdata = {15'h0000, cfg[idx].en};
    end else if (start_hit) begin
      next_rdata = {8'h00, cfg[idx].start};
    end else if (len_hit) begin
      next_rdata = {7'h00, cfg[idx].len};
    end else if (err_hit) begin
      next_rdata = err[idx];
    end
  end

  // Registered read data and access acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
      rdy   <= 1'b0;
    end else begin
      rdy <= rd_go || wr_go;
      if (rd_go) begin
        rdata <= next_rdata;
      end
    end
  end

endmodule : tbt_ber_tester

// ===== design/tbt_defs.svh
/*
  Constants of the per-stream bit error rate test block: register offsets,
  field positions, reset values and widths.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TBT_DEFS_SVH
`define TBT_DEFS_SVH

`define TBT_STREAMS        32
`define TBT_ADDR_W         14
`define TBT_DATA_W         16
`define TBT_PRBS_W         15
`define TBT_PRBS_SEED      15'h7fff
`define TBT_TAP_A          14
`define TBT_TAP_B          13
`define TBT_SYNC_BITS      4'hf

`define TBT_OFS_MODE       14'h0001
`define TBT_OFS_SRST       14'h0002
`define TBT_OFS_CTRL       14'h0100
`define TBT_OFS_START      14'h0120
`define TBT_OFS_LEN        14'h0140
`define TBT_OFS_ERR        14'h0160

`define TBT_MODE_TX_EN     4
`define TBT_MODE_RX_EN     5
`define TBT_SRST_LOOP      0
`define TBT_SRST_SWITCH    1
`define TBT_CTRL_EN        0
`define TBT_CTRL_CLR       1

`define TBT_MODE_RESET     16'h0000
`define TBT_ERR_MAX        16'hffff

`endif

// ===== design/tbt_lane.sv
/*
  One stream lane: pattern generator for the output stream and
  self-synchronising checker with saturating error counter for the input.
  Assumes the caller gives one-cycle bit strobes already gated by channel.
*/
`timescale 1ns/1ps
`include "tbt_defs.svh"

module tbt_lane (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   sw_rst,
  input  wire logic                   tx_go,
  input  wire logic                   rx_en,
  input  wire logic                   rx_go,
  input  wire logic                   rx_bit,
  input  wire logic                   clr,
  output logic                        tx_bit,
  output logic [`TBT_DATA_W-1:0]      err_cnt
);

  logic [`TBT_PRBS_W-1:0] tx_sr;
  logic [`TBT_PRBS_W-1:0] rx_sr;
  logic [3:0]             sync_cnt;
  logic                   synced;
  logic                   expect_bit;
  logic                   hit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_sr  <= `TBT_PRBS_SEED;
      tx_bit <= 1'b0;
    end else if (sw_rst) begin
      tx_sr  <= `TBT_PRBS_SEED;
      tx_bit <= 1'b0;
    end else if (tx_go) begin
      tx_sr  <= {tx_sr[`TBT_PRBS_W-2:0],
                 tx_sr[`TBT_TAP_A] ^ tx_sr[`TBT_TAP_B]};
      tx_bit <= tx_sr[`TBT_TAP_A] ^ tx_sr[`TBT_TAP_B];
    end
  end

  // local sequence loaded from received bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sr    <= '0;
      sync_cnt <= 4'h0;
    end else if (sw_rst || !rx_en) begin
      rx_sr    <= '0;
      sync_cnt <= 4'h0;
    end else if (rx_go) begin
      rx_sr <= {rx_sr[`TBT_PRBS_W-2:0], rx_bit};
      if (!synced) begin
        sync_cnt <= sync_cnt + 4'h1;
      end
    end
  end

  assign synced     = (sync_cnt == `TBT_SYNC_BITS);
  assign expect_bit = rx_sr[`TBT_TAP_A] ^ rx_sr[`TBT_TAP_B];
  assign hit        = rx_go && synced && (rx_bit != expect_bit);

  // saturating count, clear with a new error in the same cycle restarts at one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_cnt <= '0;
    end else if (sw_rst) begin
      err_cnt <= '0;
    end else if (clr) begin
      err_cnt <= hit ? 16'h0001 : 16'h0000;
    end else if (hit && err_cnt != `TBT_ERR_MAX) begin
      err_cnt <= err_cnt + 16'h0001;
    end
  end

endmodule : tbt_lane

// ===== design/tbt_pkg.sv
/*
  Types of the bit error rate test block.
  Assumes tbt_defs.svh is reachable by bare name.
*/
`include "tbt_defs.svh"

package tbt_pkg;

  // Per-stream receiver configuration
  typedef struct packed {
    logic       en;
    logic [7:0] start;
    logic [8:0] len;
  } tbt_cfg_s;

  typedef logic [`TBT_DATA_W-1:0] tbt_word_t;

endpackage : tbt_pkg

// ===== testbench/tb_top.sv
/* Self-checking bench of the bit error rate tester.
   Assumes the peer model and the checker are compiled first. */
`timescale 1ns/1ps
`include "tbt_defs.svh"
module tb_top;
  logic        clk, nrst, cs, rd, wr, bit_en, ones, rdy, loop;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, got;
  logic [7:0]  chan;
  logic [31:0] tx_sel, rx_bit, tx_bit, flip;
  logic [14:0] sr;
  int          n_mismatch, n_tests, i;
  tbt_ber_tester dut (.clk(clk), .nrst(nrst), .cs(cs), .rd(rd), .wr(wr),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rdy(rdy), .bit_en(bit_en),
    .chan_num(chan), .tx_sel(tx_sel), .rx_bit(rx_bit), .tx_bit(tx_bit),
    .soft_reset_clock_loop(loop));
  tbt_peer peer (.tx_bit(tx_bit), .flip(flip), .ones(ones), .rx_bit(rx_bit));
  // Clock of 25 ns
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // One access, acknowledged one cycle later
  task automatic acc(bit w, logic [13:0] a, logic [15:0] d);
    @(negedge clk);
    {cs, rd, wr, addr, wdata} = {1'b1, !w, w, a, d};
    @(negedge clk);
    {cs, rd, wr} = 3'b000;
    chk("rdy", {15'h0, rdy}, 16'h0001);
    got = rdata;
  endtask : acc
  task automatic rchk(string nm, logic [13:0] a, logic [15:0] e);
    acc(0, a, 16'h0000);
    chk(nm, got, e);
  endtask : rchk
  // Bit times of two cycles; lane 0 pattern followed when tc set
  task automatic bits(int n, bit tc);
    repeat (n) begin
      @(negedge clk);
      bit_en = 1;
      @(negedge clk);
      bit_en = 0;
      flip = 0;
      if (tc) begin
        sr = {sr[13:0], sr[14] ^ sr[13]};
        chk("tx_bit", {15'h0, tx_bit[0]}, {15'h0, sr[0]});
      end
    end
  endtask : bits
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    {nrst, cs, rd, wr, bit_en, ones} = 0;
    {addr, wdata, chan, tx_sel, flip} = 0;
    sr = 15'h7fff;
    repeat (4) @(negedge clk);
    nrst = 1;
    rchk("mode", `TBT_OFS_MODE, 16'h0000);
    rchk("err", `TBT_OFS_ERR, 16'h0000);
    rchk("unmapped", 14'h3fff, 16'h0000);
    acc(1, `TBT_OFS_MODE, 16'h0010);
    {chan, tx_sel} = {8'h05, 32'h8000_0001};
    bits(20, 1);
    for (i = 0; i < 32; i += 31) begin
      acc(1, `TBT_OFS_LEN + 14'(i), 16'h01ff);
      rchk("len", `TBT_OFS_LEN + 14'(i), 16'h01ff);
      acc(1, `TBT_OFS_LEN + 14'(i), 16'h0001);
      acc(1, `TBT_OFS_START + 14'(i), 16'h0005);
      rchk("start", `TBT_OFS_START + 14'(i), 16'h0005);
      acc(1, `TBT_OFS_CTRL + 14'(i), 16'h0003);
      rchk("ctrl", `TBT_OFS_CTRL + 14'(i), 16'h0001);
    end
    // receivers enabled only after the pattern runs
    acc(1, `TBT_OFS_MODE, 16'h0030);
    bits(40, 1);
    rchk("err0", `TBT_OFS_ERR, 16'h0000);
    flip = 32'h1;
    bits(20, 1);
    rchk("err0", `TBT_OFS_ERR, 16'h0003);
    rchk("err31", `TBT_OFS_ERR + 14'd31, 16'h0000);
    // Just past the window nothing is compared
    {ones, chan, tx_sel} = {1'b1, 8'h06, 32'h0};
    bits(10, 0);
    {ones, chan, tx_sel} = {1'b0, 8'h05, 32'h8000_0001};
    bits(20, 1);
    rchk("window", `TBT_OFS_ERR, 16'h0003);
    acc(1, `TBT_OFS_CTRL, 16'h0003);
    rchk("clear", `TBT_OFS_ERR, 16'h0000);
    acc(1, `TBT_OFS_MODE, 16'h0010);
    ones = 1;
    bits(20, 1);
    rchk("rx off", `TBT_OFS_ERR, 16'h0000);
    // Every bit wrong, one bit per cycle, past the ceiling
    acc(1, `TBT_OFS_MODE, 16'h0020);
    tx_sel = 0;
    @(negedge clk);
    bit_en = 1;
    repeat (65600) @(negedge clk);
    bit_en = 0;
    rchk("sat0", `TBT_OFS_ERR, 16'hffff);
    rchk("sat31", `TBT_OFS_ERR + 14'd31, 16'hffff);
    acc(1, `TBT_OFS_ERR, 16'h0000);
    rchk("ro", `TBT_OFS_ERR, 16'hffff);
    acc(1, `TBT_OFS_SRST, 16'h0003);
    chk("loop", {15'h0, loop}, 16'h0001);
    rchk("srst err", `TBT_OFS_ERR, 16'h0000);
    rchk("srst mode", `TBT_OFS_MODE, 16'h0000);
    rchk("srst", `TBT_OFS_SRST, 16'h0003);
    acc(1, `TBT_OFS_SRST, 16'h0000);
    acc(1, `TBT_OFS_MODE, 16'h0030);
    nrst = 0;
    @(negedge clk);
    nrst = 1;
    rchk("hw mode", `TBT_OFS_MODE, 16'h0000);
    finish_test();
  end
endmodule : tb_top

// ===== testbench/tbt_ber_sva.sv
/* Port checker of the bit error rate tester.
   Assumes it is bound onto tbt_ber_tester. */
`timescale 1ns/1ps
`include "tbt_defs.svh"
module tbt_ber_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        cs,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rdy,
  input wire logic        bit_en,
  input wire logic [31:0] tx_sel,
  input wire logic [31:0] tx_bit,
  input wire logic        soft_reset_clock_loop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Request seen on the port
  wire req = cs && (rd || wr);
  property p_ack; req |=> rdy; endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_no_ack; !req |=> !rdy; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_hold; !(cs && rd) |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; cs && rd && addr == 14'h3fff |=> rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not 0");
  property p_clr_rd; cs && rd && addr[13:5] == 9'h008 |=> !rdata[1];
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear bit read");
  property p_step; $changed(tx_bit) && tx_bit != 0 |-> $past(bit_en);
  endproperty
  a_step: assert property (p_step) else $error("tx moved idle");
  property p_sel;
    bit_en && tx_sel == 0 |=> tx_bit == $past(tx_bit) || tx_bit == 0;
  endproperty
  a_sel: assert property (p_sel) else $error("tx stepped unsel");
  property p_loop;
    cs && wr && addr == `TBT_OFS_SRST |=>
      soft_reset_clock_loop == $past(wdata[0]);
  endproperty
  a_loop: assert property (p_loop) else $error("loop reset bad");
  c_srst: cover property (cs && wr && addr == `TBT_OFS_SRST);
  c_sat: cover property (rdy && rdata == 16'hffff);
  c_step: cover property (bit_en && tx_sel != 0);
endmodule : tbt_ber_sva
bind tbt_ber_tester tbt_ber_sva u_sva (.clk, .nrst, .cs, .rd, .wr, .addr,
  .wdata, .rdata, .rdy, .bit_en, .tx_sel, .tx_bit, .soft_reset_clock_loop);

// ===== testbench/tbt_peer.sv
/* Peer equipment: loops each output stream back to its input.
   Assumes the bench steers bit errors and a stuck-high line. */
`timescale 1ns/1ps
module tbt_peer (
  input  wire logic [31:0] tx_bit,
  input  wire logic [31:0] flip,
  input  wire logic        ones,
  output logic      [31:0] rx_bit
);
  assign rx_bit = ones ? '1 : tx_bit ^ flip;
endmodule : tbt_peer
